// ### rtl/sdl_map.vh
// constants for the serial-loaded synthesizer divider loader
`ifndef SDL_MAP_VH
`define SDL_MAP_VH

// ----------------------------------------------------------------
// word lengths selecting the target register
// ----------------------------------------------------------------
`define SDL_CNT_W        6
`define SDL_CNT_NONE     6'h00
`define SDL_CNT_CFG      6'h08
`define SDL_CNT_REF      6'h10
`define SDL_CNT_SWL      6'h18
`define SDL_CNT_MAX      6'h3f
`define SDL_SR_W         24
`define SDL_DOUT_TAP     7

// ----------------------------------------------------------------
// field layouts
// ----------------------------------------------------------------
`define SDL_CFG_W        8
`define SDL_CFG_CASCADE  7
`define SDL_CFG_PIN_B    6
`define SDL_REF_W        13
`define SDL_REF_LSB      0
`define SDL_SEL_W        3
`define SDL_SEL_LSB      13
`define SDL_SWL_W        6
`define SDL_SWL_LSB      0
`define SDL_MAIN_W       16
`define SDL_MAIN_LSB     8
`define SDL_MAIN_SHIFT   6
`define SDL_TOT_W        22

// ----------------------------------------------------------------
// reset values
// ----------------------------------------------------------------
`define SDL_CFG_RST      8'h00
`define SDL_REF_RST      13'h0001
`define SDL_SEL_RST      3'h0
`define SDL_SWL_RST      6'h00
`define SDL_MAIN_RST     16'h0000
`define SDL_PIN_IDLE     4'h4

`endif

// ### rtl/sdl_top.v
// serial-loaded configuration, reference and feedback divider registers
`timescale 1ns/1ps
`include "sdl_map.vh"

module sdl_top (
  input  wire                     i_ref_clk,
  input  wire                     i_rst_b,
  input  wire                     i_ser_clk,
  input  wire                     i_ser_data,
  input  wire                     i_transfer_strobe,
  input  wire                     i_reference_input,
  output wire                     o_data_out,
  output wire [`SDL_CFG_W-1:0]    o_config,
  output wire [`SDL_SEL_W-1:0]    o_refout_select,
  output wire [`SDL_REF_W-1:0]    o_ref_stage1,
  output wire [`SDL_REF_W-1:0]    o_ref_stage2,
  output wire [`SDL_REF_W-1:0]    o_ref_active,
  output wire [`SDL_SWL_W-1:0]    o_swallow,
  output wire [`SDL_MAIN_W-1:0]   o_main,
  output wire [`SDL_TOT_W-1:0]    o_total_feedback_divide,
  output wire                     o_compare_frequency,
  output wire                     o_pin_b_o,
  output wire                     o_pin_b_oe
);

  // ----------------------------------------------------------------
  // helper functions
  // ----------------------------------------------------------------

  // feedback divide from main and swallow values
  function [`SDL_TOT_W-1:0] sdl_total;
    input [`SDL_MAIN_W-1:0] main_v;
    input [`SDL_SWL_W-1:0]  swl_v;
    begin
      sdl_total = ({{(`SDL_TOT_W-`SDL_MAIN_W){1'b0}}, main_v} << `SDL_MAIN_SHIFT)
                + {{(`SDL_TOT_W-`SDL_SWL_W){1'b0}}, swl_v};
    end
  endfunction

  // a ratio of zero is loaded as one, so the active ratio never shows zero
  function [`SDL_REF_W-1:0] sdl_ratio;
    input [`SDL_REF_W-1:0] r;
    begin
      if (r == {`SDL_REF_W{1'b0}}) begin
        sdl_ratio = {{(`SDL_REF_W-1){1'b0}}, 1'b1};
      end else begin
        sdl_ratio = r;
      end
    end
  endfunction

  // ----------------------------------------------------------------
  // reset synchroniser
  // ----------------------------------------------------------------
  reg rst_meta_q;
  reg rst_sync_q;

  // assert at once, release two edges later
  always @(posedge i_ref_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      rst_meta_q <= 1'b0;
      rst_sync_q <= 1'b0;
    end else begin
      rst_meta_q <= 1'b1;
      rst_sync_q <= rst_meta_q;
    end
  end

  wire rst_b = rst_sync_q;

  // ----------------------------------------------------------------
  // pin input synchronisers
  // ----------------------------------------------------------------
  reg [3:0] pin_meta_q;
  reg [3:0] pin_sync_q;
  reg [3:0] pin_last_q;

  // first stage feeds only the second stage
  // every stage resets to the idle pin levels: strobe high, the rest low;
  // a zero on the strobe bit would fake a commit edge straight after reset
  always @(posedge i_ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      pin_meta_q <= `SDL_PIN_IDLE;
      pin_sync_q <= `SDL_PIN_IDLE;
      pin_last_q <= `SDL_PIN_IDLE;
    end else begin
      pin_meta_q <= {i_reference_input, i_transfer_strobe, i_ser_data, i_ser_clk};
      pin_sync_q <= pin_meta_q;
      pin_last_q <= pin_sync_q;
    end
  end

  wire sclk_s     = pin_sync_q[0];
  wire sdat_s     = pin_sync_q[1];
  wire strobe_s   = pin_sync_q[2];
  // edge detectors compare the settled level with the one a clock older
  wire sclk_rise  = sclk_s & ~pin_last_q[0];
  wire strb_rise  = strobe_s & ~pin_last_q[2];
  wire reference_input_rise = pin_sync_q[3] & ~pin_last_q[3];

  // ----------------------------------------------------------------
  // serial shift register and bit counter
  // ----------------------------------------------------------------
  reg [`SDL_SR_W-1:0]  shift_q;
  reg [`SDL_SR_W-1:0]  shift_d;
  reg [`SDL_CNT_W-1:0] count_q;
  reg [`SDL_CNT_W-1:0] count_d;
  reg                  dout_q;
  reg                  dout_d;

  // shift while strobe low
  // the count saturates so an overlong word is ignored, not wrapped
  // the bit leaving position seven is the chain output, eight shifts late
  always @* begin
    shift_d = shift_q;
    count_d = count_q;
    dout_d  = dout_q;
    if (strb_rise) begin
      count_d = `SDL_CNT_NONE;
    end else if (sclk_rise && !strobe_s) begin
      shift_d = {shift_q[`SDL_SR_W-2:0], sdat_s};
      dout_d  = shift_q[`SDL_DOUT_TAP];
      if (count_q != `SDL_CNT_MAX) begin
        count_d = count_q + {{(`SDL_CNT_W-1){1'b0}}, 1'b1};
      end
    end
  end

  always @(posedge i_ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      shift_q <= {`SDL_SR_W{1'b0}};
      count_q <= `SDL_CNT_NONE;
      dout_q  <= 1'b0;
    end else begin
      shift_q <= shift_d;
      count_q <= count_d;
      dout_q  <= dout_d;
    end
  end

  // ----------------------------------------------------------------
  // commit decode
  // ----------------------------------------------------------------
  reg [`SDL_CFG_W-1:0] cfg_q;

  // chained device halves its count
  // the near device keeps the last word and passes the first one on
  wire                  cascade   = cfg_q[`SDL_CFG_CASCADE];
  wire [`SDL_CNT_W-1:0] eff_count = cascade ? {1'b0, count_q[`SDL_CNT_W-1:1]} : count_q;

  // copy strobe relies on serial clock held low, so count stays zero
  // a word of any other length is refused: its strobe edge only clears the count
  // limitation: in chain mode a word one bit longer also lands, since halving drops the low count bit
  wire commit_cfg  = strb_rise && (eff_count == `SDL_CNT_CFG);
  wire commit_ref  = strb_rise && (eff_count == `SDL_CNT_REF);
  wire commit_swl  = strb_rise && (eff_count == `SDL_CNT_SWL);
  wire commit_copy = strb_rise && (count_q == `SDL_CNT_NONE);

  // ----------------------------------------------------------------
  // configuration register
  // ----------------------------------------------------------------

  // own byte only
  // a config word also sets the chain mode, which applies from the next word on
  always @(posedge i_ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      cfg_q <= `SDL_CFG_RST;
    end else if (commit_cfg) begin
      cfg_q <= shift_q[`SDL_CFG_W-1:0];
    end
  end

  // ----------------------------------------------------------------
  // reference register: double-buffered ratio, select loaded directly
  // ----------------------------------------------------------------
  reg [`SDL_SEL_W-1:0] sel_q;
  reg [`SDL_REF_W-1:0] ref1_q;
  reg [`SDL_REF_W-1:0] ref2_q;

  always @(posedge i_ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      sel_q <= `SDL_SEL_RST;
    end else if (commit_ref) begin
      sel_q <= shift_q[`SDL_SEL_LSB+`SDL_SEL_W-1:`SDL_SEL_LSB];
    end
  end

  always @(posedge i_ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      ref1_q <= `SDL_REF_RST;
    end else if (commit_ref) begin
      ref1_q <= shift_q[`SDL_REF_LSB+`SDL_REF_W-1:`SDL_REF_LSB];
    end
  end

  always @(posedge i_ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      ref2_q <= `SDL_REF_RST;
    end else if (commit_copy) begin
      ref2_q <= ref1_q;
    end
  end

  // ----------------------------------------------------------------
  // swallow and main registers
  // ----------------------------------------------------------------
  reg [`SDL_SWL_W-1:0]  swl_q;
  reg [`SDL_MAIN_W-1:0] main_q;

  // only the feedback word writes these
  always @(posedge i_ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      swl_q  <= `SDL_SWL_RST;
      main_q <= `SDL_MAIN_RST;
    end else if (commit_swl) begin
      swl_q  <= shift_q[`SDL_SWL_LSB+`SDL_SWL_W-1:`SDL_SWL_LSB];
      main_q <= shift_q[`SDL_MAIN_LSB+`SDL_MAIN_W-1:`SDL_MAIN_LSB];
    end
  end

  // main times 64 plus swallow
  // registered to keep the sum off the commit path; it lags by one clock
  reg [`SDL_TOT_W-1:0] total_q;

  always @(posedge i_ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      total_q <= {`SDL_TOT_W{1'b0}};
    end else begin
      total_q <= sdl_total(main_q, swl_q);
    end
  end

  // ----------------------------------------------------------------
  // reference counter
  // ----------------------------------------------------------------
  reg [`SDL_REF_W-1:0] act_q;
  reg [`SDL_REF_W-1:0] rcnt_q;
  reg                  cmp_q;

  // reload only at terminal count
  // a stage-two change mid-cycle waits here, so the period never tears
  // ratio is reference input over compare frequency
  // the terminal test uses <= 1 so a ratio of one pulses on every rise
  always @(posedge i_ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      act_q  <= `SDL_REF_RST;
      rcnt_q <= `SDL_REF_RST;
      cmp_q  <= 1'b0;
    end else begin
      cmp_q <= 1'b0;
      if (reference_input_rise) begin
        if (rcnt_q <= {{(`SDL_REF_W-1){1'b0}}, 1'b1}) begin
          act_q  <= sdl_ratio(ref2_q);
          rcnt_q <= sdl_ratio(ref2_q);
          cmp_q  <= 1'b1;
        end else begin
          rcnt_q <= rcnt_q - {{(`SDL_REF_W-1){1'b0}}, 1'b1};
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // open-drain pin b
  // ----------------------------------------------------------------
  reg pin_b_q;

  // standby switch drive
  // pulls low while the bit is set; the pin has no high drive at all
  // registered so the pin never glitches while a config word is committed
  always @(posedge i_ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      pin_b_q <= 1'b0;
    end else begin
      pin_b_q <= cfg_q[`SDL_CFG_PIN_B];
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign o_data_out              = dout_q;
  assign o_config                = cfg_q;
  assign o_refout_select         = sel_q;
  assign o_ref_stage1            = ref1_q;
  assign o_ref_stage2            = ref2_q;
  assign o_ref_active            = act_q;
  assign o_swallow               = swl_q;
  assign o_main                  = main_q;
  assign o_total_feedback_divide = total_q;
  assign o_compare_frequency     = cmp_q;
  assign o_pin_b_o               = 1'b0;
  assign o_pin_b_oe              = pin_b_q;

endmodule // sdl_top

// ### testbench/sdl_master.sv
// serial master model driving clock, data and strobe
`timescale 1ns/1ps

module sdl_master (
  input  wire i_clk,
  output reg  o_ser_clk,
  output reg  o_ser_data,
  output reg  o_strobe
);
  // idle: clock low, strobe high
  initial begin
    o_ser_clk = 1'b0;
    o_ser_data = 1'b0;
    o_strobe = 1'b1;
  end

  // four clocks per level leaves margin over the three-clock sync
  task hold;
    begin
      repeat (4) @(posedge i_clk);
    end
  endtask

  task send(input [23:0] w, input integer n);
    integer b;
    begin
      @(posedge i_clk);
      o_strobe <= 1'b0;
      for (b = n - 1; b >= 0; b = b - 1) begin
        o_ser_data <= w[b];
        hold;
        o_ser_clk <= 1'b1;
        hold;
        o_ser_clk <= 1'b0;
      end
      hold;
      o_strobe <= 1'b1;
      o_ser_data <= ~o_ser_data; // no stale bit left on the line
      repeat (8) @(posedge i_clk);
      #1;
    end
  endtask

  task copy;
    begin
      @(posedge i_clk);
      o_strobe <= 1'b0;
      hold;
      o_strobe <= 1'b1;
      repeat (8) @(posedge i_clk);
      #1;
    end
  endtask
endmodule // sdl_master

// ### testbench/sdl_props.sv
// port checker for the divider loader
`timescale 1ns/1ps
`include "sdl_map.vh"

module sdl_props (
  input wire                   i_ref_clk,
  input wire                   i_rst_b,
  input wire                   i_transfer_strobe,
  input wire [`SDL_CFG_W-1:0]  o_config,
  input wire [`SDL_REF_W-1:0]  o_ref_stage1,
  input wire [`SDL_REF_W-1:0]  o_ref_stage2,
  input wire [`SDL_REF_W-1:0]  o_ref_active,
  input wire [`SDL_SWL_W-1:0]  o_swallow,
  input wire [`SDL_MAIN_W-1:0] o_main,
  input wire [`SDL_TOT_W-1:0]  o_total_feedback_divide,
  input wire                   o_compare_frequency,
  input wire                   o_pin_b_o,
  input wire                   o_pin_b_oe
);
  // ----------------------------------------------------------------
  // register relations
  // ----------------------------------------------------------------
  default clocking cb @(posedge i_ref_clk);
  endclocking
  default disable iff (!i_rst_b);

  a_pin_b_low: assert property (!o_pin_b_o)
    else $error("pin b data not low");
  a_pin_b_cfg: assert property ($changed(o_pin_b_oe) |-> o_pin_b_oe == o_config[`SDL_CFG_PIN_B])
    else $error("pin b enable not from config");
  a_total_calc: assert property (o_total_feedback_divide ==
    {$past(o_main), 6'h00} + $past(o_swallow))
    else $error("total divide wrong");
  a_commit_strobe: assert property ($changed(o_config) || $changed(o_ref_stage1) ||
    $changed(o_main) |-> $past(i_transfer_strobe) && $past(i_transfer_strobe, 3))
    else $error("commit without strobe rise");
  a_stage1_only: assert property ($changed(o_ref_stage1) |->
    $stable(o_ref_stage2) && $stable(o_ref_active))
    else $error("stage one load moved later stages");
  a_stage2_copy: assert property ($changed(o_ref_stage2) |->
    o_ref_stage2 == o_ref_stage1 && $stable(o_ref_stage1))
    else $error("stage two not a copy");
  a_active_tc: assert property ($changed(o_ref_active) |-> o_ref_active == o_ref_stage2 &&
    (o_compare_frequency || $past(o_compare_frequency)))
    else $error("ratio swapped mid cycle");
  a_ref_isolate: assert property ($changed(o_ref_stage1) || $changed(o_ref_stage2) |->
    $stable(o_config) && $stable(o_swallow) && $stable(o_main))
    else $error("reference load touched others");
  a_cfg_isolate: assert property ($changed(o_config) |->
    $stable(o_ref_stage1) && $stable(o_main) && $stable(o_swallow))
    else $error("config load touched others");
  a_pulse_one: assert property (o_compare_frequency |=> !o_compare_frequency)
    else $error("compare pulse too long");

  c_copy: cover property ($changed(o_ref_stage2));
  c_pulse: cover property (o_compare_frequency);
  c_chain: cover property ($changed(o_config) && o_config[`SDL_CFG_CASCADE]);
endmodule // sdl_props

bind sdl_top sdl_props u_props (.*);

// ### testbench/sdl_top_tb.sv
// self-checking bench for the divider loader
`timescale 1ns/1ps
`include "sdl_map.vh"

module sdl_top_tb;
  reg                     i_ref_clk;
  reg                     i_rst_b;
  reg                     i_reference_input;
  wire                    ser_clk;
  wire                    ser_data;
  wire                    strobe;
  wire [`SDL_CFG_W-1:0]   cfg;
  wire [`SDL_SEL_W-1:0]   sel;
  wire [`SDL_REF_W-1:0]   st1;
  wire [`SDL_REF_W-1:0]   st2;
  wire [`SDL_REF_W-1:0]   act;
  wire [`SDL_SWL_W-1:0]   swl;
  wire [`SDL_MAIN_W-1:0]  mainv;
  wire [`SDL_TOT_W-1:0]   tot;
  wire                    pulse;
  wire                    pb_o;
  wire                    pb_oe;
  wire                    dout;
  integer                 mismatches;
  integer                 cmp_count;
  integer                 pulses;
  integer                 k;

  sdl_top DUT (
    .i_ref_clk(i_ref_clk), .i_rst_b(i_rst_b), .i_ser_clk(ser_clk),
    .i_ser_data(ser_data), .i_transfer_strobe(strobe),
    .i_reference_input(i_reference_input), .o_data_out(dout), .o_config(cfg),
    .o_refout_select(sel), .o_ref_stage1(st1), .o_ref_stage2(st2),
    .o_ref_active(act), .o_swallow(swl), .o_main(mainv),
    .o_total_feedback_divide(tot), .o_compare_frequency(pulse),
    .o_pin_b_o(pb_o), .o_pin_b_oe(pb_oe)
  );
  sdl_master mst (.i_clk(i_ref_clk), .o_ser_clk(ser_clk), .o_ser_data(ser_data),
    .o_strobe(strobe));

  // 50 MHz clock
  initial i_ref_clk = 1'b0;
  always #10 i_ref_clk = ~i_ref_clk;

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  task check(input [31:0] seen, input [31:0] exp);
    begin
      cmp_count = cmp_count + 1;
      if (seen !== exp) begin
        mismatches = mismatches + 1;
        $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
      end
    end
  endtask

  task print_verdict;
    begin
      $display("comparisons %0d mismatches %0d", cmp_count, mismatches);
      if (mismatches == 0 && cmp_count > 0) begin
        $display("Result: passed");
      end else begin
        $display("Result: failed");
      end
      $finish;
    end
  endtask

  // n reference rises, eight clocks each, counting compare pulses
  task tick_ref(input integer n);
    begin
      pulses = 0;
      repeat (n) begin
        for (k = 0; k < 8; k = k + 1) begin
          @(posedge i_ref_clk);
          i_reference_input <= (k < 4);
          #1;
          if (pulse === 1'b1) pulses = pulses + 1;
        end
      end
    end
  endtask

  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task t_ref_load;
    begin
      check(st2, 13'h0001);
      // ratio 7 stands for reference over compare rate
      mst.send({3'h5, 13'h0007}, 16);
      check(sel, 3'h5);
      check(st1, 13'h0007);
      check(st2, 13'h0001);
      check(act, 13'h0001);
      check(cfg, 8'h00);
      $display("test ref load done");
    end
  endtask

  task t_copy;
    begin
      mst.copy;
      check(st2, 13'h0007);
      check(st1, 13'h0007);
      check(act, 13'h0001);
      tick_ref(1);
      check(pulses, 1);
      check(act, 13'h0007);
      tick_ref(20);
      check(pulses, 2);
      $display("test copy done");
    end
  endtask

  task t_feedback;
    begin
      mst.send({16'h0123, 2'b11, 6'h2a}, 24);
      check(mainv, 16'h0123);
      check(swl, 6'h2a);
      check(tot, 32'h123 * 64 + 32'h2a);
      check(st2, 13'h0007);
      check(dout, 1'b1);
      $display("test feedback done");
    end
  endtask

  task t_config;
    begin
      mst.send(24'h40, 8);
      check(cfg, 8'h40);
      check(pb_oe, 1'b1);
      check(pb_o, 1'b0);
      mst.send(24'hfff, 12);
      check(cfg, 8'h40);
      check(mainv, 16'h0123);
      mst.send(24'h00, 8);
      check(pb_oe, 1'b0);
      $display("test config done");
    end
  endtask

  task t_chain;
    begin
      mst.send(24'h80, 8);
      mst.send(24'h3c81, 16);
      check(cfg, 8'h81);
      check(st1, 13'h0007);
      check(sel, 3'h5);
      check(swl, 6'h2a);
      mst.send(24'h3c00, 16);
      check(cfg, 8'h00);
      $display("test chain done");
    end
  endtask

  // main sequence
  initial begin
    mismatches = 0;
    cmp_count = 0;
    i_rst_b = 1'b0;
    i_reference_input = 1'b0;
    repeat (10) @(posedge i_ref_clk);
    i_rst_b <= 1'b1;
    repeat (8) @(posedge i_ref_clk);
    #1;
    t_ref_load;
    t_copy;
    t_feedback;
    t_config;
    t_chain;
    print_verdict;
  end

  // hang guard
  initial begin
    #1000000;
    mismatches = mismatches + 1;
    print_verdict;
  end
endmodule // sdl_top_tb
